// ==== pmd_params.svh ====
`ifndef PMD_PARAMS_SVH
`define PMD_PARAMS_SVH

// register byte offsets, main core bank
`define MAIN_LOCK_OFS   32'h0000_0000
`define MAIN_OFF_1_OFS  32'h0000_0004
`define MAIN_OFF_2_OFS  32'h0000_0008
`define MAIN_OFF_3_OFS  32'h0000_000c
`define MAIN_OFF_4_OFS  32'h0000_0010
`define MAIN_OFF_6_OFS  32'h0000_0014
`define MAIN_OFF_7_OFS  32'h0000_0018
`define MAIN_OFF_8_OFS  32'h0000_001c

// register byte offsets, secondary core bank
`define SEC_LOCK_OFS    32'h0000_0020
`define SEC_OFF_1_OFS   32'h0000_0024
`define SEC_OFF_2_OFS   32'h0000_0028
`define SEC_OFF_4_OFS   32'h0000_0030
`define SEC_OFF_6_OFS   32'h0000_0034
`define SEC_OFF_7_OFS   32'h0000_0038
`define SEC_OFF_8_OFS   32'h0000_003c

// implemented-bit masks, main core bank
`define MAIN_LOCK_MASK  16'h0800
`define MAIN_OFF_1_MASK 16'h0efb
`define MAIN_OFF_2_MASK 16'h00ff
`define MAIN_OFF_3_MASK 16'h0082
`define MAIN_OFF_4_MASK 16'h0008
`define MAIN_OFF_6_MASK 16'h3f00
`define MAIN_OFF_7_MASK 16'h0108
`define MAIN_OFF_8_MASK 16'h183e

// implemented-bit masks, secondary core bank
`define SEC_LOCK_MASK   16'h0800
`define SEC_OFF_1_MASK  16'h0ea9
`define SEC_OFF_2_MASK  16'h000f
`define SEC_OFF_4_MASK  16'h0008
`define SEC_OFF_6_MASK  16'h0300
`define SEC_OFF_7_MASK  16'h0702
`define SEC_OFF_8_MASK  16'h443c
`define NO_REG_MASK     16'h0000

// reset value of every disable and lock register
`define OFF_RESET       16'h0000

// field positions
`define LOCK_BIT        11
`define GAIN3_BIT       14
`define GAIN2_BIT       10
`define CELL4_BIT       5
`define CELL1_BIT       2

// bus responses
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11

`endif

// ==== pmd_pkg.sv ====
`default_nettype none

package pmd_pkg;

  typedef logic [15:0]       off_word_t;
  typedef logic [7:0][15:0]  off_bank_t;
  typedef logic [15:0][15:0] off_file_t;

  // named disable levels of the secondary eighth register
  typedef struct packed {
    logic gain_stage_three_off;
    logic gain_stage_two_off;
    logic logic_cell_four_off;
    logic logic_cell_three_off;
    logic logic_cell_two_off;
    logic logic_cell_one_off;
  } second_off_8_s;

  // state of one lockable disable register
  typedef struct packed {
    off_word_t value;
  } off_reg_s;

  // state of the bus slave and the gating outputs
  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          aw_got;
    logic          w_got;
    logic          aw_hit;
    logic [3:0]    aw_idx;
    off_word_t     wdata;
    logic [1:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [3:0]    rd_idx;
    off_bank_t     main_run;
    off_bank_t     second_run;
    second_off_8_s second_off_8;
  } slave_state_s;

endpackage

`default_nettype wire

// ==== lockable_off_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmd_params.svh"

module lockable_off_reg #(
  parameter logic [15:0] MASK = 16'h0000
) (
  input  wire logic              aclk,     // system clock
  input  wire logic              aresetn,  // sync reset, active low
  input  wire logic              wr_en,    // write strobe for this word
  input  wire logic              permit,   // bank write permission
  input  wire pmd_pkg::off_word_t wr_data, // write data
  input  wire logic [1:0]        wr_be,    // byte enables
  output pmd_pkg::off_word_t     value     // stored disable bits
);
  import pmd_pkg::*;

  off_reg_s st;
  off_reg_s next_st;

  // masked byte-lane write, held while locked
  always_comb begin
    next_st = st;
    if (wr_en && permit) begin
      if (wr_be[0]) begin
        next_st.value[7:0] = wr_data[7:0] & MASK[7:0];
      end
      if (wr_be[1]) begin
        next_st.value[15:8] = wr_data[15:8] & MASK[15:8];
      end
    end
  end

  // register the state, all bits clear at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.value <= `OFF_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;

  a_unimpl_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (value & ~MASK) == 16'h0000)
    else $error("unimplemented disable bit set");

  a_locked_word_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && !permit |=> $stable(value))
    else $error("locked disable register changed");

endmodule // lockable_off_reg

`default_nettype wire

// ==== module_off_bank.sv ====
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmd_params.svh"

// Notes on behaviour
// - secondary eighth bit 14 turns gain three off
// - secondary eighth bit 10 turns gain two off
// - secondary eighth bits 5..2 turn cells off
// - unimplemented disable bits always read zero
// - implemented bits read/write, clear at reset
// - disable writes only while lock bit set

module module_off_bank (
  input  wire logic                  aclk,          // system clock
  input  wire logic                  aresetn,       // sync reset, active low
  input  wire logic [31:0]           s_axi_awaddr,  // write address
  input  wire logic                  s_axi_awvalid, // write address valid
  output logic                       s_axi_awready, // write address ready
  input  wire logic [31:0]           s_axi_wdata,   // write data
  input  wire logic [3:0]            s_axi_wstrb,   // write strobes
  input  wire logic                  s_axi_wvalid,  // write data valid
  output logic                       s_axi_wready,  // write data ready
  output logic [1:0]                 s_axi_bresp,   // write response
  output logic                       s_axi_bvalid,  // write response valid
  input  wire logic                  s_axi_bready,  // write response ready
  input  wire logic [31:0]           s_axi_araddr,  // read address
  input  wire logic                  s_axi_arvalid, // read address valid
  output logic                       s_axi_arready, // read address ready
  output logic [31:0]                s_axi_rdata,   // read data
  output logic [1:0]                 s_axi_rresp,   // read response
  output logic                       s_axi_rvalid,  // read data valid
  input  wire logic                  s_axi_rready,  // read data ready
  output pmd_pkg::off_bank_t         main_clk_run,  // main module clock enables
  output pmd_pkg::off_bank_t         second_clk_run, // second module clock enables
  output pmd_pkg::second_off_8_s     second_off_8   // named eighth disable levels
);
  import pmd_pkg::*;

  slave_state_s st;
  slave_state_s next_st;
  off_file_t    vals;
  logic [1:0]   bank_permit;
  logic         wr_fire;
  logic [15:0]  wr_hit;
  logic [4:0]   ar_dec;
  logic [4:0]   aw_dec;

  // implemented bits of each register slot
  function automatic logic [15:0] mask_of(input logic [3:0] idx);
    logic [15:0] m;
    m = `NO_REG_MASK;
    unique case (idx)
      4'h0: m = `MAIN_LOCK_MASK;
      4'h1: m = `MAIN_OFF_1_MASK;
      4'h2: m = `MAIN_OFF_2_MASK;
      4'h3: m = `MAIN_OFF_3_MASK;
      4'h4: m = `MAIN_OFF_4_MASK;
      4'h5: m = `MAIN_OFF_6_MASK;
      4'h6: m = `MAIN_OFF_7_MASK;
      4'h7: m = `MAIN_OFF_8_MASK;
      4'h8: m = `SEC_LOCK_MASK;
      4'h9: m = `SEC_OFF_1_MASK;
      4'ha: m = `SEC_OFF_2_MASK;
      4'hb: m = `NO_REG_MASK;
      4'hc: m = `SEC_OFF_4_MASK;
      4'hd: m = `SEC_OFF_6_MASK;
      4'he: m = `SEC_OFF_7_MASK;
      4'hf: m = `SEC_OFF_8_MASK;
    endcase
    return m;
  endfunction

  // address to {hit, slot}; anything else misses
  function automatic logic [4:0] decode(input logic [31:0] addr);
    logic [4:0] r;
    r = 5'h00;
    case (addr)
      `MAIN_LOCK_OFS:  r = 5'h10;
      `MAIN_OFF_1_OFS: r = 5'h11;
      `MAIN_OFF_2_OFS: r = 5'h12;
      `MAIN_OFF_3_OFS: r = 5'h13;
      `MAIN_OFF_4_OFS: r = 5'h14;
      `MAIN_OFF_6_OFS: r = 5'h15;
      `MAIN_OFF_7_OFS: r = 5'h16;
      `MAIN_OFF_8_OFS: r = 5'h17;
      `SEC_LOCK_OFS:   r = 5'h18;
      `SEC_OFF_1_OFS:  r = 5'h19;
      `SEC_OFF_2_OFS:  r = 5'h1a;
      `SEC_OFF_4_OFS:  r = 5'h1c;
      `SEC_OFF_6_OFS:  r = 5'h1d;
      `SEC_OFF_7_OFS:  r = 5'h1e;
      `SEC_OFF_8_OFS:  r = 5'h1f;
      default:         r = 5'h00;
    endcase
    return r;
  endfunction

  // a write completes once address and data are both held
  assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
  assign aw_dec  = decode(s_axi_awaddr);
  assign ar_dec  = decode(s_axi_araddr);

  // lock bit of each bank opens its disable words
  assign bank_permit[0] = vals[0][`LOCK_BIT];
  assign bank_permit[1] = vals[8][`LOCK_BIT];

  // one lockable word per slot; lock words are always writable
  for (genvar i = 0; i < 16; i++) begin : g_word
    localparam logic [3:0] IDX = 4'(i);

    assign wr_hit[i] = wr_fire && st.aw_hit && (st.aw_idx == IDX);

    lockable_off_reg #(
      .MASK (mask_of(IDX))
    ) u_word (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (wr_hit[i]),
      .permit  ((IDX[2:0] == 3'd0) || bank_permit[IDX[3]]),
      .wr_data (st.wdata),
      .wr_be   (st.wstrb),
      .value   (vals[i])
    );
  end

  // bus slave and clock gating next state
  always_comb begin
    next_st = st;

    // write address channel
    if (s_axi_awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_got  = 1'b1;
      next_st.aw_hit  = aw_dec[4];
      next_st.aw_idx  = aw_dec[3:0];
    end

    // write data channel, low half only carries bits
    if (s_axi_wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata[15:0];
      next_st.wstrb  = s_axi_wstrb[1:0];
    end

    // write completes and answers
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = st.aw_hit ? `RESP_OKAY : `RESP_DECERR;
    end

    // write response taken, reopen both channels
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // read address taken, data ready next cycle
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rd_idx  = ar_dec[3:0];
      next_st.rresp   = ar_dec[4] ? `RESP_OKAY : `RESP_DECERR;
      next_st.rdata   = 32'h0000_0000;
      if (ar_dec[4]) begin
        next_st.rdata[15:0] = vals[ar_dec[3:0]] & mask_of(ar_dec[3:0]);
      end
    end

    // read data taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // clock enables: running while implemented and not disabled; lock words gate nothing
    next_st.main_run[0]   = 16'h0000;
    next_st.second_run[0] = 16'h0000;
    for (int s = 1; s < 8; s++) begin
      next_st.main_run[s]   = mask_of(4'(s)) & ~vals[s];
      next_st.second_run[s] = mask_of(4'(s + 8)) & ~vals[s + 8];
    end

    // named disable levels of the secondary eighth word
    next_st.second_off_8.gain_stage_three_off = vals[15][`GAIN3_BIT];
    next_st.second_off_8.gain_stage_two_off   = vals[15][`GAIN2_BIT];
    next_st.second_off_8.logic_cell_four_off  = vals[15][`CELL4_BIT];
    next_st.second_off_8.logic_cell_three_off = vals[15][`CELL4_BIT - 1];
    next_st.second_off_8.logic_cell_two_off   = vals[15][`CELL1_BIT + 1];
    next_st.second_off_8.logic_cell_one_off   = vals[15][`CELL1_BIT];
  end

  // register the state; readies open after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign s_axi_awready  = st.awready;
  assign s_axi_wready   = st.wready;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_arready  = st.arready;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;
  assign s_axi_rvalid   = st.rvalid;
  assign main_clk_run   = st.main_run;
  assign second_clk_run = st.second_run;
  assign second_off_8   = st.second_off_8;

  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  // permitted write reaching the secondary eighth word
  sequence s_open_wr8;
    wr_fire && st.aw_hit && (st.aw_idx == 4'hf) && bank_permit[1];
  endsequence

  // both write channels taken at one edge
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_gain_three_write: assert property (
    s_open_wr8 ##0 st.wstrb[1] |-> ##2
      second_off_8.gain_stage_three_off == $past(st.wdata[14], 2))
    else $error("gain three disable level wrong");

  a_gain_two_write: assert property (
    s_open_wr8 ##0 st.wstrb[1] |-> ##2
      second_off_8.gain_stage_two_off == $past(st.wdata[10], 2))
    else $error("gain two disable level wrong");

  a_logic_cell_write: assert property (
    s_open_wr8 ##0 st.wstrb[0] |-> ##2
      {second_off_8.logic_cell_four_off, second_off_8.logic_cell_three_off,
       second_off_8.logic_cell_two_off, second_off_8.logic_cell_one_off}
        == $past(st.wdata[5:2], 2))
    else $error("logic cell disable levels wrong");

  a_read_unimpl_zero: assert property (
    s_axi_rvalid && (s_axi_rresp == `RESP_OKAY) |->
      ((s_axi_rdata[15:0] & ~mask_of(st.rd_idx)) == 16'h0000) &&
      (s_axi_rdata[31:16] == 16'h0000))
    else $error("unimplemented bits read nonzero");

  a_reset_all_clear: assert property (
    $rose(aresetn) |-> (vals == '0) && !s_axi_bvalid && !s_axi_rvalid)
    else $error("disable bits not clear after reset");

  a_locked_no_write: assert property (
    wr_fire && st.aw_hit && (st.aw_idx[2:0] != 3'd0) &&
      !bank_permit[st.aw_idx[3]] |=> $stable(vals))
    else $error("write took effect while locked");

  a_gate_follows_off: assert property (
    s_open_wr8 ##0 st.wstrb[1] ##0 st.wdata[14] |-> ##2
      !second_clk_run[7][14] ##1 !second_clk_run[7][14])
    else $error("gain three clock still running");

  a_write_answer: assert property (
    s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

endmodule // module_off_bank

`default_nettype wire

// ==== test_module_off_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmd_params.svh"

module test_module_off_bank;
  import pmd_pkg::*;

  // implemented masks by word index, secondary bank from index 8
  localparam off_word_t MASKS [16] = '{`MAIN_LOCK_MASK, `MAIN_OFF_1_MASK, `MAIN_OFF_2_MASK,
    `MAIN_OFF_3_MASK, `MAIN_OFF_4_MASK, `MAIN_OFF_6_MASK, `MAIN_OFF_7_MASK, `MAIN_OFF_8_MASK,
    `SEC_LOCK_MASK, `SEC_OFF_1_MASK, `SEC_OFF_2_MASK, `NO_REG_MASK, `SEC_OFF_4_MASK,
    `SEC_OFF_6_MASK, `SEC_OFF_7_MASK, `SEC_OFF_8_MASK};

  logic          aclk          = 1'b0;
  logic          aresetn       = 1'b0;
  logic [31:0]   s_axi_awaddr  = '0;
  logic          s_axi_awvalid = 1'b0;
  logic          s_axi_awready;
  logic [31:0]   s_axi_wdata   = '0;
  logic [3:0]    s_axi_wstrb   = '0;
  logic          s_axi_wvalid  = 1'b0;
  logic          s_axi_wready;
  logic [1:0]    s_axi_bresp;
  logic          s_axi_bvalid;
  logic          s_axi_bready  = 1'b0;
  logic [31:0]   s_axi_araddr  = '0;
  logic          s_axi_arvalid = 1'b0;
  logic          s_axi_arready;
  logic [31:0]   s_axi_rdata;
  logic [1:0]    s_axi_rresp;
  logic          s_axi_rvalid;
  logic          s_axi_rready  = 1'b0;
  off_bank_t     main_clk_run;
  off_bank_t     second_clk_run;
  second_off_8_s off8;
  off_word_t     shadow [16];
  logic [33:0]   exp_b [$];
  logic [33:0]   exp_r [$];
  int            error_cnt     = 0;
  int            check_count   = 0;

  // 50 MHz system clock
  always #10 aclk = ~aclk;

  module_off_bank u_module_off_bank (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .main_clk_run(main_clk_run), .second_clk_run(second_clk_run), .second_off_8(off8)
  );

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (exp_b.size() != 0 || exp_r.size() != 0) begin
      error_cnt++;
    end
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic mapped(input logic [31:0] a);
    return a < 32'h40 && a[1:0] == 2'b00 && a != 32'h2c;
  endfunction

  // one write; the shadow copy follows the lock of the bank
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s);
    logic      aw_ok;
    logic      w_ok;
    off_word_t bm;
    logic [3:0] i;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bm = {{8{s[1]}}, {8{s[0]}}};
    i = a[5:2];
    exp_b.push_back(mapped(a) ? {32'h0, `RESP_OKAY} : {32'h0, `RESP_DECERR});
    if (mapped(a) && (i[2:0] == 3'd0 || shadow[{i[3], 3'd0}][`LOCK_BIT]))
      shadow[i] = ((shadow[i] & ~bm) | (d[15:0] & bm)) & MASKS[i];
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= {s, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // one read, expectation from the shadow copy
  task automatic rd(input logic [31:0] a);
    exp_r.push_back(mapped(a) ? {`RESP_OKAY, 16'h0, shadow[a[5:2]]} : {`RESP_DECERR, 32'h0});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // clock enables and named disable levels against the shadow copy
  task automatic check_outs();
    @(posedge aclk);
    for (int k = 1; k < 8; k++) begin
      chk(34'(main_clk_run[k]), 34'(MASKS[k] & ~shadow[k]));
      chk(34'(second_clk_run[k]), 34'(MASKS[k + 8] & ~shadow[k + 8]));
    end
    chk(34'(main_clk_run[0]), 34'h0);
    chk(34'(second_clk_run[0]), 34'h0);
    chk(34'(off8.gain_stage_three_off), 34'(shadow[15][`GAIN3_BIT]));
    chk(34'(off8.gain_stage_two_off), 34'(shadow[15][`GAIN2_BIT]));
    chk(34'({off8.logic_cell_four_off, off8.logic_cell_three_off, off8.logic_cell_two_off,
             off8.logic_cell_one_off}), 34'(shadow[15][`CELL4_BIT:`CELL1_BIT]));
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (shadow[k]) shadow[k] = `OFF_RESET;
    @(posedge aclk);
  endtask

  // scoreboard: oldest note against each answer
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      if (exp_b.size() > 0) chk({32'h0, s_axi_bresp}, exp_b.pop_front());
      else chk({32'h0, s_axi_bresp}, 34'hx);
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (exp_r.size() > 0) chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
      else chk({s_axi_rresp, s_axi_rdata}, 34'hx);
    end
  end

  // hang guard, about ten times the expected run
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial begin
    logic [31:0] a;
    void'($urandom(7));
    do_reset();
    check_outs();
    for (int i = 0; i < 16; i++) rd(32'(i * 4));
    // writes while locked are dropped
    wr(`SEC_OFF_8_OFS, 32'h0000_ffff, 2'b11);
    wr(`MAIN_OFF_1_OFS, 32'h0000_ffff, 2'b11);
    rd(`SEC_OFF_8_OFS);
    rd(`MAIN_OFF_1_OFS);
    check_outs();
    // unmapped and unaligned places
    wr(32'h2c, 32'hffff_ffff, 2'b11);
    wr(32'h40, 32'hffff_ffff, 2'b11);
    rd(32'h2c);
    rd(32'h42);
    // open both banks; lock words keep only their one bit
    wr(`MAIN_LOCK_OFS, 32'hffff_ffff, 2'b11);
    wr(`SEC_LOCK_OFS, 32'hffff_ffff, 2'b11);
    rd(`MAIN_LOCK_OFS);
    rd(`SEC_LOCK_OFS);
    // every bit set, unimplemented ones read zero
    for (int i = 1; i < 16; i++) begin
      if (i != 8) wr(32'(i * 4), 32'hffff_ffff, 2'b11);
      rd(32'(i * 4));
    end
    check_outs();
    // random byte-lane traffic over the whole map, locks included
    repeat (200) begin
      a = 32'($urandom_range(15, 0)) << 2;
      wr(a, $urandom, 2'($urandom));
      rd(a);
      check_outs();
    end
    // relock the secondary bank and try to invert its eighth word
    wr(`SEC_LOCK_OFS, 32'h0, 2'b11);
    wr(`SEC_OFF_8_OFS, {16'h0, ~shadow[15]}, 2'b11);
    rd(`SEC_OFF_8_OFS);
    check_outs();
    // second reset in mid-run
    do_reset();
    check_outs();
    for (int i = 0; i < 16; i++) rd(32'(i * 4));
    wrap_up();
  end

endmodule // test_module_off_bank
`default_nettype wire
